// ---- acc_pkg.sv ----
/*
 * Shared constants of the converter control block: register offsets,
 * field positions, reset values and state encodings.
 * Assumes a 32-bit APB slave port and a single system clock.
 */
package acc_pkg;
    localparam int          ACC_NCFG       = 4;
    localparam int          ACC_DW         = 32;
    localparam int          ACC_SAMPLE_W   = 24;
    localparam int          ACC_AW         = 8;
    localparam int          ACC_CONV_HALF  = 6;
    localparam int          ACC_CP_RATIO   = 3;
    localparam int          ACC_CP_HALF    = ACC_CONV_HALF / ACC_CP_RATIO;
    localparam int          ACC_CP_MIN     = 2;
    localparam int          ACC_CP_MAX     = 4;

    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_SEL        = 8'h04;
    localparam logic [7:0]  OFF_CFG0       = 8'h08;
    localparam logic [7:0]  OFF_CFG3       = 8'h14;
    localparam logic [7:0]  OFF_STATUS     = 8'h18;
    localparam logic [7:0]  OFF_RESULT     = 8'h1c;
    localparam logic [7:0]  OFF_INT_STAT   = 8'h20;
    localparam logic [7:0]  OFF_INT_MASK   = 8'h24;

    localparam int          CTRL_START     = 0;
    localparam int          CTRL_STOP      = 1;
    localparam int          CTRL_HW_EN     = 2;
    localparam int          CTRL_SE        = 3;
    localparam int          CTRL_EXT_CLK   = 4;
    localparam int          CTRL_MOD_EN    = 5;

    localparam int          CFG_CONT       = 0;
    localparam int          CFG_RES_LO     = 3;
    localparam int          CFG_RES_HI     = 7;
    localparam logic [4:0]  RES_16         = 5'h10;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0081;

    localparam logic [1:0]  SEL_RESET      = 2'h0;
    localparam int          SEL_W          = 2;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b01,
        ACC_RUN  = 2'b10
    } acc_state_e;
endpackage

// ---- acc_sync.sv ----
/*
 * Three-stage pin synchroniser with agreement filter and rising edge
 * detect against the registered previous level.
 * Assumes the input may change at any time relative to sys_clk_i.
 */
`timescale 1ns/100ps
module acc_sync (
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } acc_sync_s;

    acc_sync_s st;
    acc_sync_s next_st;

    always_comb begin
        next_st      = st;
        next_st.s1   = pin_i;
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        next_st.rise = 1'b0;
        // Level moves only once stages two and three agree
        if (st.s2 == st.s3) begin
            next_st.lvl  = st.s3;
            next_st.rise = st.s3 & ~st.lvl; // R14
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.lvl;
    assign rise_o  = st.rise;
endmodule

// ---- acc_clk_div.sv ----
/*
 * Free-running clock divider: output toggles every HALF cycles.
 * Assumes HALF is at least one; the output is a registered level.
 */
`timescale 1ns/100ps
module acc_clk_div #(
    parameter int HALF = 2
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    output logic      clk_o
);
    localparam int CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          clk;
    } acc_div_s;

    acc_div_s st;
    acc_div_s next_st;

    always_comb begin
        next_st = st;
        if (st.cnt == LAST) begin
            next_st.cnt = '0;
            next_st.clk = ~st.clk;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign clk_o = st.clk;
endmodule

// ---- acc_ctrl.sv ----
/*
 * Converter control: four run-time configurations, start/stop control,
 * hardware trigger, input mode, clock source and charge-pump clock,
 * end-of-conversion interrupts per configuration, APB register slave.
 * Assumes a decimator that pulses conv_done_i with a sign-extended sample.
 */
// Register access over APB and the address map are this design's own decisions.
// Behaviour
// (R01) Hold four configurations, switchable while running
// (R02) First configuration active until software selects
// (R03) Software keeps one input mode for all
// (R04) Per-configuration interrupt; vector follows selection
// (R05) Other references match first or internal
// (R06) Differential default; single-ended grounds negative input
// (R07) Signed results; single-ended 16-bit reaches all-ones
// (R08) Software or hardware rising edge starts; stop ends
// (R09) Hardware edge ignored while converting
// (R10) Hardware trigger off by default, optional input
// (R11) Charge-pump clock two to four times converter; three times on internal clock, fixed sys_clk_i/4 with external
// (R12) Optional modulator input driven by interconnect
// (R13) Converter clock internal or external input
// (R14) Trigger synchronised, edge from previous value
`timescale 1ns/100ps
module acc_ctrl
    import acc_pkg::*;
#(
    parameter bit HW_SOC_OPT = 1'b0,
    parameter bit MOD_IN_OPT = 1'b0
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ACC_AW-1:0]       paddr,
    input  wire logic [ACC_DW-1:0]       pwdata,
    output logic [ACC_DW-1:0]            prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    hw_soc_i,
    input  wire logic                    ext_conv_clk_i,
    input  wire logic                    modulator_bitstream_input_i,
    input  wire logic                    conv_done_i,
    input  wire logic [ACC_SAMPLE_W-1:0] conv_data_i,
    output logic                         conv_run_o,
    output logic [ACC_DW-1:0]            conv_cfg_o,
    output logic                         neg_in_to_ground_o,
    output logic                         ext_clk_sel_o,
    output logic                         conv_clk_o,
    output logic                         cp_clk_o,
    output logic                         mod_bitstream_o,
    output logic                         mod_in_sel_o,
    output logic [SEL_W-1:0]             eoc_vector_o,
    output logic                         irq_o
);
    typedef struct packed {
        logic [ACC_NCFG-1:0][ACC_DW-1:0] cfg;
        logic [SEL_W-1:0]                sel;
        logic                            hw_en;
        logic                            se;
        logic                            ext_clk;
        logic                            mod_en;
        logic [ACC_NCFG-1:0]             int_stat;
        logic [ACC_NCFG-1:0]             int_mask;
        logic [ACC_DW-1:0]               result;
        logic [ACC_DW-1:0]               rdata;
        logic                            slverr;
        logic                            queued;
        logic                            hw_run;
        acc_state_e                      state;
    } acc_regs_s;

    acc_regs_s st;
    acc_regs_s next_st;

    logic trig_rise;
    logic ext_clk_lvl;
    logic int_conv_clk;
    logic cp_clk;

    // Hardware trigger only exists when the option is built in
    generate
        if (HW_SOC_OPT) begin : g_hw
            acc_sync u_trig (
                .sys_clk_i (sys_clk_i),
                .rst_b_i   (rst_b_i),
                .pin_i     (hw_soc_i),
                .level_o   (),
                .rise_o    (trig_rise)
            );
        end else begin : g_nohw
            assign trig_rise = 1'b0; // R10
        end
    endgenerate

    acc_sync u_extclk (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .pin_i     (ext_conv_clk_i),
        .level_o   (ext_clk_lvl),
        .rise_o    ()
    );

    acc_clk_div #(.HALF(ACC_CONV_HALF)) u_conv_div (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .clk_o     (int_conv_clk)
    );

    acc_clk_div #(.HALF(ACC_CP_HALF)) u_cp_div (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .clk_o     (cp_clk)
    );

    function automatic logic [ACC_DW-1:0] sext(
        input logic [ACC_SAMPLE_W-1:0] d
    );
        sext = {{(ACC_DW - ACC_SAMPLE_W){d[ACC_SAMPLE_W-1]}}, d};
    endfunction

    logic                setup;
    logic                wr;
    logic                mapped;
    logic                hw_start;
    logic                sw_start;
    logic                sw_stop;
    logic [ACC_NCFG-1:0] eoc_set;
    logic [ACC_NCFG-1:0] w1c;
    logic [4:0]          res;
    logic                cfg_hit;
    logic [SEL_W-1:0]    cfg_idx;

    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite;
    assign cfg_hit  = (paddr >= OFF_CFG0) && (paddr <= OFF_CFG3)
                      && (paddr[1:0] == 2'h0);
    assign cfg_idx  = SEL_W'((paddr - OFF_CFG0) >> 2);
    assign mapped   = cfg_hit || paddr == OFF_CTRL || paddr == OFF_SEL
                      || paddr == OFF_STATUS || paddr == OFF_RESULT
                      || paddr == OFF_INT_STAT || paddr == OFF_INT_MASK;
    assign sw_start = wr && paddr == OFF_CTRL && pwdata[CTRL_START];
    assign sw_stop  = wr && paddr == OFF_CTRL && pwdata[CTRL_STOP];
    assign hw_start = trig_rise & st.hw_en & (st.state == ACC_IDLE); // R09
    assign res      = st.cfg[st.sel][CFG_RES_HI:CFG_RES_LO];

    always_comb begin
        next_st = st;
        eoc_set = '0;
        w1c     = '0;
        // Register writes take effect in the access phase
        if (wr && mapped) begin
            if (paddr == OFF_CTRL) begin
                next_st.hw_en   = pwdata[CTRL_HW_EN];
                next_st.se      = pwdata[CTRL_SE];
                next_st.ext_clk = pwdata[CTRL_EXT_CLK];
                next_st.mod_en  = pwdata[CTRL_MOD_EN];
            end
            if (paddr == OFF_SEL) begin
                next_st.sel = pwdata[SEL_W-1:0]; // R01 R02
            end
            if (cfg_hit) begin
                next_st.cfg[cfg_idx] = pwdata; // R01
            end
            if (paddr == OFF_INT_MASK) begin
                next_st.int_mask = pwdata[ACC_NCFG-1:0];
            end
            if (paddr == OFF_INT_STAT) begin
                w1c = pwdata[ACC_NCFG-1:0];
            end
        end
        // Conversion sequencer
        case (st.state)
            ACC_IDLE: begin
                if (sw_start || hw_start) begin // R08
                    next_st.state  = ACC_RUN;
                    next_st.hw_run = hw_start;
                    next_st.queued = 1'b0;
                end
            end
            ACC_RUN: begin
                if (sw_start) begin
                    next_st.queued = 1'b1;
                end
                if (conv_done_i) begin
                    eoc_set[st.sel] = 1'b1; // R04
                    if (st.se && res == RES_16
                        && !conv_data_i[ACC_SAMPLE_W-1]) begin
                        next_st.result = {16'h0000, conv_data_i[15:0]}; // R07
                    end else begin
                        next_st.result = sext(conv_data_i); // R07
                    end
                    if (!st.cfg[st.sel][CFG_CONT] && !st.hw_run
                        && !st.queued && !sw_start) begin
                        next_st.state = ACC_IDLE;
                    end else begin
                        next_st.queued = 1'b0;
                    end
                end
                if (sw_stop) begin // R08
                    next_st.state  = ACC_IDLE;
                    next_st.queued = 1'b0;
                    next_st.hw_run = 1'b0;
                end
            end
            default: begin
                next_st.state = ACC_IDLE;
            end
        endcase
        // Event set wins over a write-one clear in the same cycle
        next_st.int_stat = (st.int_stat & ~w1c) | eoc_set;
        // Read data and error are prepared in the setup phase
        if (setup) begin
            next_st.slverr = ~mapped;
            next_st.rdata  = '0;
            if (cfg_hit) begin
                next_st.rdata = st.cfg[cfg_idx];
            end
            case (paddr)
                OFF_CTRL: begin
                    next_st.rdata[CTRL_HW_EN]   = st.hw_en;
                    next_st.rdata[CTRL_SE]      = st.se;
                    next_st.rdata[CTRL_EXT_CLK] = st.ext_clk;
                    next_st.rdata[CTRL_MOD_EN]  = st.mod_en;
                end
                OFF_SEL:      next_st.rdata[SEL_W-1:0] = st.sel;
                OFF_STATUS:   next_st.rdata[0] = (st.state == ACC_RUN);
                OFF_RESULT:   next_st.rdata = st.result;
                OFF_INT_STAT: next_st.rdata[ACC_NCFG-1:0] = st.int_stat;
                OFF_INT_MASK: next_st.rdata[ACC_NCFG-1:0] = st.int_mask;
                default:      next_st.rdata = next_st.rdata;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st       <= '0;
            st.cfg   <= {ACC_NCFG{CFG_RESET}};
            st.sel   <= SEL_RESET; // R02
            st.hw_en <= 1'b0; // R10
            st.se    <= 1'b0; // R06
            st.state <= ACC_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata             = st.rdata;
    assign pready             = psel & penable;
    assign pslverr            = psel & penable & st.slverr;
    assign conv_run_o         = (st.state == ACC_RUN);
    assign conv_cfg_o         = st.cfg[st.sel]; // R01
    assign neg_in_to_ground_o = st.se; // R06
    assign ext_clk_sel_o      = st.ext_clk; // R13
    assign conv_clk_o         = st.ext_clk ? ext_clk_lvl : int_conv_clk;
    assign cp_clk_o           = cp_clk; // R11
    assign mod_in_sel_o       = MOD_IN_OPT & st.mod_en; // R12
    assign mod_bitstream_o    = mod_in_sel_o & modulator_bitstream_input_i;
    assign eoc_vector_o       = st.sel; // R04
    assign irq_o              = |(st.int_stat & st.int_mask);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_sel_written;
        psel && penable && pwrite && paddr == OFF_SEL;
    endsequence

    sequence s_hw_edge_busy;
        trig_rise && st.state == ACC_RUN;
    endsequence

    a_cfg_drive: assert property ( // R01
        wr && cfg_hit && cfg_idx == eoc_vector_o
        |=> conv_cfg_o == $past(pwdata))
        else $error("Configuration output not the selected one");
    a_sel_holds: assert property ( // R02
        !(psel && penable && pwrite && paddr == OFF_SEL)
        |=> $stable(eoc_vector_o))
        else $error("Selection changed without a write");
    a_sel_value: assert property ( // R02
        s_sel_written |=> eoc_vector_o == $past(pwdata[SEL_W-1:0]))
        else $error("Selection not taken from write");
    a_vector_flag: assert property ( // R04
        conv_done_i && conv_run_o |=> st.int_stat[$past(eoc_vector_o)])
        else $error("End flag not set for active configuration");
    a_se_ground: assert property ( // R06
        wr && paddr == OFF_CTRL
        |=> neg_in_to_ground_o == $past(pwdata[CTRL_SE]))
        else $error("Negative input grounding wrong");
    a_se16_wide: assert property ( // R07
        conv_run_o && conv_done_i && st.se && res == RES_16
        && conv_data_i[15:0] == 16'hffff && !conv_data_i[ACC_SAMPLE_W-1]
        |=> st.result == 32'h0000_ffff)
        else $error("Single-ended result clipped");
    a_sw_start: assert property ( // R08
        !conv_run_o && sw_start |=> conv_run_o)
        else $error("Software start missed");
    a_stop_ends: assert property ( // R08
        conv_run_o && sw_stop |=> !conv_run_o
        ##1 (!conv_run_o || $past(sw_start || hw_start)))
        else $error("Stop did not end conversion");
    a_hw_ignored: assert property ( // R09
        s_hw_edge_busy |=> !conv_run_o || st.hw_run == $past(st.hw_run))
        else $error("Busy trigger was taken");
    a_hw_disabled: assert property ( // R10
        !st.hw_en && !conv_run_o && !sw_start |=> !conv_run_o)
        else $error("Disabled trigger started conversion");
    a_cp_ratio: assert property ( // R11
        ACC_CONV_HALF >= ACC_CP_MIN * ACC_CP_HALF
        && ACC_CONV_HALF <= ACC_CP_MAX * ACC_CP_HALF)
        else $error("Charge-pump ratio out of range");
    a_mod_gate: assert property ( // R12
        wr && paddr == OFF_CTRL
        |=> mod_in_sel_o == (MOD_IN_OPT && $past(pwdata[CTRL_MOD_EN])))
        else $error("Modulator input leaks while absent");
    a_irq_level: assert property ( // R04
        $rose(irq_o) |-> $past(|eoc_set) || $past(wr))
        else $error("Interrupt rose without cause");
endmodule

// ---- acc_dec_model.sv ----
/*
 * Decimator stand-in: one sample pulse a set delay after run begins,
 * repeated while run stays high.
 * Assumes run_i is the control block's conversion run level.
 */
`timescale 1ns/100ps
module acc_dec_model (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        run_i,
    input  wire logic [3:0]  lat_i,
    input  wire logic [23:0] smp_i,
    output logic             done_o,
    output logic [23:0]      data_o
);
    logic [3:0] cnt;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt    <= 4'h0;
            done_o <= 1'b0;
            data_o <= 24'h0;
        end else begin
            done_o <= 1'b0;
            data_o <= ~data_o;
            if (!run_i) begin
                cnt <= 4'h0;
            end else if (cnt >= lat_i) begin
                cnt    <= 4'h0;
                done_o <= 1'b1;
                data_o <= smp_i;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// ---- adc_conversion_control_tb_top.sv ----
/*
 * Self-checking bench for the converter control block.
 * Assumes zero-wait APB answers and the decimator stand-in model.
 */
`timescale 1ns/100ps
module adc_conversion_control_tb_top;
    import acc_pkg::*;
    logic        sys_clk_i = 0;
    logic        rst_b_i = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata, conv_cfg_o, rd, cfg_m [4], msk, ctrl_m;
    logic        pready, pslverr, er, done, run, ngnd, xsel, cclk, cpclk;
    logic        mbit, msel, irq;
    logic        hw = 0;
    logic        ext = 0;
    logic        mod_in = 0;
    logic [23:0] dat;
    logic [23:0] smp = 0;
    logic [3:0]  lat = 4'h2;
    logic [1:0]  vec;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;
    int          seed, k, j, p, cpn, cvn, dn;

    acc_ctrl #(.HW_SOC_OPT(1'b1), .MOD_IN_OPT(1'b1)) dut_u (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_soc_i(hw), .ext_conv_clk_i(ext),
        .modulator_bitstream_input_i(mod_in), .conv_done_i(done),
        .conv_data_i(dat), .conv_run_o(run), .conv_cfg_o(conv_cfg_o),
        .neg_in_to_ground_o(ngnd), .ext_clk_sel_o(xsel),
        .conv_clk_o(cclk), .cp_clk_o(cpclk), .mod_bitstream_o(mbit),
        .mod_in_sel_o(msel), .eoc_vector_o(vec), .irq_o(irq));

    acc_dec_model dec_u (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .run_i(run),
        .lat_i(lat), .smp_i(smp), .done_o(done), .data_o(dat));

    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge cpclk) cpn++;
    always @(posedge cclk) cvn++;
    always @(posedge sys_clk_i) if (done) dn++;

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_i);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do @(posedge sys_clk_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input logic v, input int n);
        int i;
        for (i = 0; i < n && run !== v; i++) @(negedge sys_clk_i);
        chk(32'(run), 32'(v));
    endtask

    function automatic logic [31:0] exp_res(logic [23:0] s, int se,
                                            logic [4:0] r);
        if (se == 1 && r == RES_16 && !s[23])
            return {16'h0, s[15:0]};
        return {{8{s[23]}}, s};
    endfunction

    initial begin
        seed = 33943;
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(negedge sys_clk_i);
        chk(conv_cfg_o, CFG_RESET);
        chk(32'(vec), 32'h0);
        chk(32'(ngnd), 32'h0);
        for (k = 0; k < ACC_NCFG; k++) begin
            apb(1'b0, OFF_CFG0 + 8'(4 * k), 32'h0);
            chk(rd, CFG_RESET);
        end
        apb(1'b0, OFF_SEL, 32'h0);
        chk(rd, 32'(SEL_RESET));
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        for (p = 0; p < 2; p++) begin
            ctrl_m = (p == 1) ? 32'h8 : 32'h0;
            msk = (p == 1) ? 32'h5 : 32'hf;
            apb(1'b1, OFF_CTRL, ctrl_m);
            apb(1'b1, OFF_INT_MASK, msk);
            @(negedge sys_clk_i);
            chk(32'(ngnd), 32'(p));
            // One input mode and reference for every slot
            for (k = 0; k < ACC_NCFG; k++) begin
                cfg_m[k] = ($random(seed) & 32'hffff_ff06)
                         | ((k % 2 == 0) ? 32'h80 : 32'h58);
                apb(1'b1, OFF_CFG0 + 8'(4 * k), cfg_m[k]);
            end
            for (k = 0; k < ACC_NCFG; k++) begin
                j = 3 - k;
                apb(1'b1, OFF_SEL, 32'(j));
                smp <= (j == 0) ? 24'h00ffff : 24'($random(seed));
                lat <= 4'(1 + ($random(seed) & 7));
                @(negedge sys_clk_i);
                chk(conv_cfg_o, cfg_m[j]);
                chk(32'(vec), 32'(j));
                apb(1'b1, OFF_CTRL, ctrl_m | 32'h1);
                wt(1'b1, 2);
                wt(1'b0, 40);
                apb(1'b0, OFF_RESULT, 32'h0);
                chk(rd, exp_res(smp, p, cfg_m[j][7:3]));
                apb(1'b0, OFF_INT_STAT, 32'h0);
                chk(rd, 32'h1 << j);
                chk(32'(irq), 32'(msk[j]));
                apb(1'b1, OFF_INT_STAT, 32'h1 << j);
                @(negedge sys_clk_i);
                chk(32'(irq), 32'h0);
            end
        end
        apb(1'b1, OFF_CTRL, 32'h0);
        @(posedge sys_clk_i) hw <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        hw <= 1'b0;
        @(negedge sys_clk_i);
        chk(32'(run), 32'h0);
        apb(1'b1, OFF_CTRL, 32'h4);
        lat <= 4'h3;
        @(posedge sys_clk_i) hw <= 1'b1;
        wt(1'b1, 10);
        @(posedge sys_clk_i) hw <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        hw <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        hw <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        apb(1'b1, OFF_CTRL, 32'h6);
        wt(1'b0, 3);
        repeat (10) @(negedge sys_clk_i);
        chk(32'(run), 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        // A start while busy queues exactly one more conversion
        lat <= 4'h4;
        apb(1'b1, OFF_CTRL, 32'h1);
        dn = 0;
        apb(1'b1, OFF_CTRL, 32'h1);
        wt(1'b0, 40);
        chk(32'(dn), 32'h2);
        cpn = 0;
        cvn = 0;
        repeat (480) @(posedge sys_clk_i);
        chk(32'(cvn > 0 && cpn >= 2 * cvn && cpn <= 4 * cvn), 1);
        apb(1'b1, OFF_CTRL, 32'h30);
        mod_in <= 1'b1;
        @(negedge sys_clk_i) cvn = 0;
        for (k = 0; k < 20; k++) begin
            repeat (5) @(posedge sys_clk_i);
            ext <= ~ext;
        end
        @(negedge sys_clk_i);
        chk(32'(cvn >= 9 && cvn <= 10), 1);
        chk({mbit, msel, xsel}, 32'h7);
        apb(1'b1, OFF_CTRL, 32'h0);
        repeat (4) @(negedge sys_clk_i);
        chk({mbit, msel, xsel}, 32'h0);
        end_sim();
    end
endmodule
